/* hdl/fsco_entry.sv */
// Entry pattern detector for serial and parallel programming modes
`timescale 1ns/1ps
`default_nettype none
module fsco_entry (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ser_data_i,
    input  wire logic       ser_clk_i,
    input  wire logic [3:0] par_nib_i,
    output logic            ser_hit_o,
    output logic            par_hit_o
);
    logic       clk_d_ff;
    logic [3:0] sh_ff;
    logic [1:0] bitc_ff;
    logic [1:0] nibc_ff;
    logic [1:0] pstep_ff;
    logic [3:0] pprev_ff;

    // Serial: sample data on rising serial clock, count nibbles of 'hC
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            clk_d_ff  <= 1'b0;
            sh_ff     <= 4'h0;
            bitc_ff   <= 2'h0;
            nibc_ff   <= 2'h0;
            ser_hit_o <= 1'b0;
        end
        else
        begin
            clk_d_ff <= ser_clk_i;
            if (ser_clk_i && !clk_d_ff && !ser_hit_o)
            begin
                sh_ff   <= {sh_ff[2:0], ser_data_i};
                bitc_ff <= bitc_ff + 2'h1;
                if (bitc_ff == 2'h3)
                begin
                    if ({sh_ff[2:0], ser_data_i} == fsco_pkg::SER_ENTRY_NIB)
                    begin
                        nibc_ff <= nibc_ff + 2'h1;
                        if (nibc_ff == 2'h2)
                            ser_hit_o <= 1'b1;
                    end
                    else
                        nibc_ff <= 2'h0;
                end
            end
        end
    end

    // Parallel: step on each change of the nibble, 5 then A then 5
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pstep_ff  <= 2'h0;
            pprev_ff  <= 4'h0;
            par_hit_o <= 1'b0;
        end
        else
        begin
            pprev_ff <= par_nib_i;
            if (par_nib_i != pprev_ff && !par_hit_o)
            begin
                unique case (pstep_ff)
                    2'h0: pstep_ff <= (par_nib_i == fsco_pkg::PAR_STEP_A)
                                      ? 2'h1 : 2'h0;
                    2'h1: pstep_ff <= (par_nib_i == fsco_pkg::PAR_STEP_B)
                                      ? 2'h2 : 2'h0;
                    2'h2:
                    begin
                        if (par_nib_i == fsco_pkg::PAR_STEP_A)
                            par_hit_o <= 1'b1;
                        pstep_ff <= 2'h0;
                    end
                    default: pstep_ff <= 2'h0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* hdl/fsco_sync.sv */
// Two-flop synchroniser with optional short noise filter
`timescale 1ns/1ps
`default_nettype none
module fsco_sync #(
    parameter int FILT = 1
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic d_i,
    input  wire logic filt_en_i,
    output logic      q_o
);
    // Counter is 8 bits wide, so longer filters cannot be served
    if (FILT < 1 || FILT > 256)
    begin
        $error("FILT must lie between 1 and 256");
    end

    logic       s1_ff;
    logic       s2_ff;
    logic [7:0] cnt_ff;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
        end
    end

    // Filter holds off a change until it has stood FILT cycles
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            q_o    <= 1'b0;
            cnt_ff <= 8'h00;
        end
        else if (!filt_en_i || s2_ff == q_o)
        begin
            q_o    <= s2_ff;
            cnt_ff <= 8'h00;
        end
        else if (cnt_ff >= 8'(FILT - 1))
        begin
            q_o    <= s2_ff;
            cnt_ff <= 8'h00;
        end
        else
        begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* hdl/fsco_top.sv */
// Flash security policy, mode entry and configuration option byte
`timescale 1ns/1ps
`default_nettype none
module fsco_top (
    input  wire logic                clk_i,
    input  wire logic                sys_rst_i,
    input  wire logic [7:0]          nv_cfg_i,
    input  wire logic                debug_serial_data_i,
    input  wire logic                debug_serial_clock_i,
    input  wire logic [3:0]          par_nib_i,
    input  wire logic                dbg_ovr_we_i,
    input  wire logic [7:0]          dbg_ovr_data_i,
    input  wire fsco_pkg::fsco_req_t req_i,
    input  wire logic [15:0]         reg_addr_i,
    input  wire logic [7:0]          reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic [7:0]               reg_rdata_o,
    output fsco_pkg::fsco_rsp_t      rsp_o,
    output logic                     in_system_programming_o,
    output logic                     parallel_programming_mode_o,
    output logic                     sub_osc_enable_o,
    output logic                     main_osc_enable_o,
    output logic                     debug_pin_filter_select_o,
    output logic [15:0]              boot_region_end_o,
    output logic                     code_memory_lock_o,
    output logic                     boot_code_lock_o
);
    ////////////////////////////////////////////////////////////////////
    logic       dsd_s;
    logic       dsc_s;
    logic [3:0] pn_s1_ff;
    logic [3:0] pn_s2_ff;
    logic       ser_hit;
    logic       par_hit;
    logic [7:0] nv_cfg_ff;
    logic [7:0] cfg_ff;
    logic       loaded_ff;
    logic       prog_mode;
    logic       allow;
    logic       boot_hit;
    logic       lock_clr;
    logic [15:0] boot_end;

    // Debug pins: filter path when select is 0, plain sync when 1
    fsco_sync #(.FILT(fsco_pkg::FILT_CYC)) u_sync_dat (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (debug_serial_data_i),
        .filt_en_i (!cfg_ff[fsco_pkg::PIN_FILT_BIT]),
        .q_o       (dsd_s)
    );
    fsco_sync #(.FILT(fsco_pkg::FILT_CYC)) u_sync_clk (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (debug_serial_clock_i),
        .filt_en_i (!cfg_ff[fsco_pkg::PIN_FILT_BIT]),
        .q_o       (dsc_s)
    );

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pn_s1_ff <= 4'h0;
            pn_s2_ff <= 4'h0;
        end
        else
        begin
            pn_s1_ff <= par_nib_i;
            pn_s2_ff <= pn_s1_ff;
        end
    end

    fsco_entry u_entry (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .ser_data_i (dsd_s),
        .ser_clk_i  (dsc_s),
        .par_nib_i  (pn_s2_ff),
        .ser_hit_o  (ser_hit),
        .par_hit_o  (par_hit)
    );

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            in_system_programming_o     <= 1'b0;
            parallel_programming_mode_o <= 1'b0;
        end
        else
        begin
            in_system_programming_o     <= ser_hit;
            parallel_programming_mode_o <= par_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Option byte: stored copy and working copy. Stored copy only loses
    // lock bits through a qualified bulk erase.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            loaded_ff <= 1'b0;
            nv_cfg_ff <= fsco_pkg::CFG_OPT_RESET;
        end
        else if (!loaded_ff)
        begin
            loaded_ff <= 1'b1;
            nv_cfg_ff <= nv_cfg_i & fsco_pkg::CFG_RO_MASK;
        end
        else if (lock_clr)
        begin
            nv_cfg_ff[fsco_pkg::CODE_LOCK_BIT] <= 1'b0;
            nv_cfg_ff[fsco_pkg::BOOT_LOCK_BIT] <= 1'b0;
        end
    end

    // Debug override holds except on the code lock bit
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            cfg_ff <= fsco_pkg::CFG_OPT_RESET;
        else if (!loaded_ff)
            cfg_ff <= nv_cfg_i & fsco_pkg::CFG_RO_MASK;
        else if (dbg_ovr_we_i && in_system_programming_o)
        begin
            cfg_ff <= dbg_ovr_data_i & fsco_pkg::CFG_RO_MASK;
            cfg_ff[fsco_pkg::CODE_LOCK_BIT] <=
                nv_cfg_ff[fsco_pkg::CODE_LOCK_BIT];
        end
        else
        begin
            cfg_ff[fsco_pkg::CODE_LOCK_BIT] <=
                nv_cfg_ff[fsco_pkg::CODE_LOCK_BIT];
            // Override of the boot lock must stand until erase or reset
            if (lock_clr)
                cfg_ff[fsco_pkg::BOOT_LOCK_BIT] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        unique case (cfg_ff[fsco_pkg::BOOT_REGION_SIZE_MSB:fsco_pkg::BOOT_REGION_SIZE_LSB])
            2'b00: boot_end = fsco_pkg::BOOT_END_1K;
            2'b01: boot_end = fsco_pkg::BOOT_END_2K;
            2'b10: boot_end = fsco_pkg::BOOT_END_4K;
            2'b11: boot_end = fsco_pkg::BOOT_END_8K;
        endcase
    end

    assign prog_mode = in_system_programming_o | parallel_programming_mode_o;
    assign boot_hit  = (req_i.addr <= boot_end) && !req_i.otp
                       && (req_i.op == fsco_pkg::FSCO_OP_PE
                           || req_i.byte_erase);
    // Only a qualified bulk erase may return the stored lock bits to 0
    assign lock_clr  = req_i.valid && allow
                       && req_i.op == fsco_pkg::FSCO_OP_BE
                       && req_i.timer > fsco_pkg::ERASE_TIMER_MIN;

    // Access policy; in a programming mode a code lock bit of 0 grants every access except a boot-locked boot region erase
    always_comb
    begin
        allow = 1'b0;
        if (!prog_mode)
            allow = !req_i.otp && req_i.op != fsco_pkg::FSCO_OP_BE;
        else if (!cfg_ff[fsco_pkg::CODE_LOCK_BIT])
            allow = 1'b1;
        else if (!req_i.otp)
            allow = req_i.op == fsco_pkg::FSCO_OP_BE;
        else
            allow = req_i.op == fsco_pkg::FSCO_OP_RD
                    || req_i.op == fsco_pkg::FSCO_OP_BE;
        // Boot lock blocks byte and page erase of the boot region
        if (cfg_ff[fsco_pkg::BOOT_LOCK_BIT] && boot_hit)
            allow = 1'b0;
        // Nothing is granted before the option byte is loaded
        if (!loaded_ff)
            allow = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            rsp_o <= '0;
        else
        begin
            rsp_o.done    <= req_i.valid;
            rsp_o.granted <= req_i.valid && allow;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            sub_osc_enable_o          <= 1'b0;
            main_osc_enable_o         <= 1'b0;
            debug_pin_filter_select_o <= 1'b0;
            boot_region_end_o         <= fsco_pkg::BOOT_END_1K;
            code_memory_lock_o        <= 1'b0;
            boot_code_lock_o          <= 1'b0;
        end
        else
        begin
            sub_osc_enable_o          <=
                cfg_ff[fsco_pkg::SUB_OSC_BIT];
            main_osc_enable_o         <=
                cfg_ff[fsco_pkg::MAIN_OSC_BIT];
            debug_pin_filter_select_o <=
                cfg_ff[fsco_pkg::PIN_FILT_BIT];
            boot_region_end_o         <= boot_end;
            code_memory_lock_o        <=
                cfg_ff[fsco_pkg::CODE_LOCK_BIT];
            boot_code_lock_o          <=
                cfg_ff[fsco_pkg::BOOT_LOCK_BIT];
        end
    end

    // Register port: writes are ignored, option byte is read-only
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i && reg_addr_i == fsco_pkg::CFG_OPT_ADDR)
            reg_rdata_o <= cfg_ff;
        else
            reg_rdata_o <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////
    property p_user_be;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && !prog_mode && req_i.op == fsco_pkg::FSCO_OP_BE)
        |=> !rsp_o.granted;
    endproperty
    a_user_be: assert property (p_user_be) else $error("user BE granted");

    property p_user_otp;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && !prog_mode && req_i.otp) |=> !rsp_o.granted;
    endproperty
    a_user_otp: assert property (p_user_otp)
        else $error("user OTP granted");

    property p_open;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && loaded_ff && prog_mode && !cfg_ff[0]
         && !(cfg_ff[1] && boot_hit)) |=> rsp_o.granted;
    endproperty
    a_open: assert property (p_open) else $error("unlocked refused");

    property p_locked;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && prog_mode && cfg_ff[0]
         && req_i.op == fsco_pkg::FSCO_OP_WR) |=> !rsp_o.granted;
    endproperty
    a_locked: assert property (p_locked)
        else $error("locked write granted");

    property p_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        (loaded_ff && $fell(nv_cfg_ff[0])) |->
        $past(req_i.valid && req_i.op == fsco_pkg::FSCO_OP_BE
              && req_i.timer > fsco_pkg::ERASE_TIMER_MIN);
    endproperty
    a_clear: assert property (p_clear)
        else $error("lock cleared wrongly");

    property p_code_memory_lock;
        @(posedge clk_i) disable iff (sys_rst_i)
        loaded_ff ##1 loaded_ff |-> cfg_ff[0] == $past(nv_cfg_ff[0]);
    endproperty
    a_code_memory_lock: assert property (p_code_memory_lock)
        else $error("code lock overridden");

    property p_rd;
        @(posedge clk_i) disable iff (sys_rst_i)
        (reg_rd_i && reg_addr_i == fsco_pkg::CFG_OPT_ADDR) |=>
        reg_rdata_o == $past(cfg_ff);
    endproperty
    a_rd: assert property (p_rd) else $error("option byte read wrong");

    property p_boot;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && cfg_ff[1] && boot_hit) |=> !rsp_o.granted;
    endproperty
    a_boot: assert property (p_boot) else $error("boot erase granted");

    property p_osc;
        @(posedge clk_i) disable iff (sys_rst_i)
        1'b1 |=> sub_osc_enable_o == $past(cfg_ff[5])
                 && main_osc_enable_o == $past(cfg_ff[4]);
    endproperty
    a_osc: assert property (p_osc) else $error("osc enable mismatch");

    c_isp: cover property (@(posedge clk_i) $rose(in_system_programming_o));
    c_par: cover property (@(posedge clk_i)
        $rose(parallel_programming_mode_o));
    c_clr: cover property (@(posedge clk_i) loaded_ff && $fell(nv_cfg_ff[0]));
endmodule
`default_nettype wire

/* shared/fsco_pkg.sv */
// Package: constants and types for the flash security and option byte block
`default_nettype none
package fsco_pkg;
    localparam logic [15:0] CFG_OPT_ADDR      = 16'h2F5D;
    localparam logic [7:0]  CFG_OPT_RESET     = 8'h00;
    localparam int          BOOT_REGION_SIZE_MSB         = 7;
    localparam int          BOOT_REGION_SIZE_LSB         = 6;
    localparam int          SUB_OSC_BIT       = 5;
    localparam int          MAIN_OSC_BIT      = 4;
    localparam int          PIN_FILT_BIT      = 2;
    localparam int          BOOT_LOCK_BIT     = 1;
    localparam int          CODE_LOCK_BIT     = 0;
    localparam logic [7:0]  CFG_RO_MASK       = 8'hF7;
    localparam logic [3:0]  SER_ENTRY_NIB     = 4'hC;
    localparam logic [3:0]  PAR_STEP_A        = 4'h5;
    localparam logic [3:0]  PAR_STEP_B        = 4'hA;
    localparam logic [7:0]  ERASE_TIMER_MIN   = 8'h80;
    localparam logic [15:0] BOOT_END_1K       = 16'h03FF;
    localparam logic [15:0] BOOT_END_2K       = 16'h07FF;
    localparam logic [15:0] BOOT_END_4K       = 16'h0FFF;
    localparam logic [15:0] BOOT_END_8K       = 16'h1FFF;
    localparam int          CLK_HZ            = 20000000;
    localparam int          FILT_NS           = 10;
    localparam int          FILT_CYC_RAW      =
        (FILT_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int          FILT_CYC          =
        (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;

    typedef enum logic [1:0] {FSCO_OP_RD, FSCO_OP_WR, FSCO_OP_PE, FSCO_OP_BE}
        fsco_op_t;

    typedef struct packed {
        logic       valid;
        fsco_op_t   op;
        logic       otp;
        logic [15:0] addr;
        logic       byte_erase;
        logic [7:0] timer;
    } fsco_req_t;

    typedef struct packed {
        logic       done;
        logic       granted;
    } fsco_rsp_t;
endpackage
`default_nettype wire

/* tb/fsco_bench.sv */
// Self-checking bench for the flash security and option byte block
`timescale 1ns/1ps
`default_nettype none
module fsco_bench;
    logic                clk;
    logic                sys_rst;
    logic [7:0]          nv_cfg;
    logic                ser_data;
    logic                ser_clk;
    logic [3:0]          par_nib;
    logic                dbg_we;
    logic [7:0]          dbg_data;
    fsco_pkg::fsco_req_t req;
    fsco_pkg::fsco_rsp_t rsp;
    logic [15:0]         reg_addr;
    logic [7:0]          reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [7:0]          reg_rdata;
    logic                in_system_programming;
    logic                par_mode;
    logic                sub_osc;
    logic                main_osc;
    logic                pin_sel;
    logic [15:0]         boot_end;
    logic                code_lock;
    logic                boot_lock;
    int                  err_count;
    int                  num_checks;

    fsco_top u_fsco_top (
        .clk_i                       (clk),
        .sys_rst_i                   (sys_rst),
        .nv_cfg_i                    (nv_cfg),
        .debug_serial_data_i         (ser_data),
        .debug_serial_clock_i        (ser_clk),
        .par_nib_i                   (par_nib),
        .dbg_ovr_we_i                (dbg_we),
        .dbg_ovr_data_i              (dbg_data),
        .req_i                       (req),
        .reg_addr_i                  (reg_addr),
        .reg_wdata_i                 (reg_wdata),
        .reg_wr_i                    (reg_wr),
        .reg_rd_i                    (reg_rd),
        .reg_rdata_o                 (reg_rdata),
        .rsp_o                       (rsp),
        .in_system_programming_o     (in_system_programming),
        .parallel_programming_mode_o (par_mode),
        .sub_osc_enable_o            (sub_osc),
        .main_osc_enable_o           (main_osc),
        .debug_pin_filter_select_o   (pin_sel),
        .boot_region_end_o           (boot_end),
        .code_memory_lock_o          (code_lock),
        .boot_code_lock_o            (boot_lock)
    );

    fsco_tool u_fsco_tool (
        .clk_i      (clk),
        .ser_data_o (ser_data),
        .ser_clk_o  (ser_clk),
        .par_nib_o  (par_nib)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %0t: bit %b, want %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %0t: word %h, want %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic [7:0] nv);
        @(posedge clk);
        sys_rst <= 1'b1;
        nv_cfg  <= nv;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Issue one access and compare done and granted in the answer cycle
    task automatic do_req(input logic [1:0] op, input logic otp,
                          input logic [15:0] a, input logic bye,
                          input logic [7:0] tmr, input logic exp);
        @(posedge clk);
        req <= '{1'b1, fsco_pkg::fsco_op_t'(op), otp, a, bye, tmr};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        chk_bit(rsp.done, 1'b1);
        chk_bit(rsp.granted, exp);
    endtask

    // Index is {otp, op}; addresses sit outside every boot region
    task automatic chk_policy(input logic [7:0] exp);
        for (int i = 0; i < 8; i++)
            do_req(i[1:0], i[2], 16'h2000, 1'b0, 8'h00, exp[i]);
    endtask

    task automatic chk_opts(input logic [7:0] nv);
        logic [7:0]  e;
        logic [7:0]  got;
        logic [15:0] bend;
        e = nv & 8'hF7;
        case (e[7:6])
            2'b00: bend = 16'h03FF;
            2'b01: bend = 16'h07FF;
            2'b10: bend = 16'h0FFF;
            default: bend = 16'h1FFF;
        endcase
        chk_word(boot_end, bend);
        chk_bit(sub_osc, e[5]);
        chk_bit(main_osc, e[4]);
        chk_bit(pin_sel, e[2]);
        chk_bit(boot_lock, e[1]);
        chk_bit(code_lock, e[0]);
        reg_read(fsco_pkg::CFG_OPT_ADDR, got);
        chk_word({8'h00, got}, {8'h00, e});
        // Writes must leave the byte alone; a plain gap is not enough
        reg_write(fsco_pkg::CFG_OPT_ADDR, ~e);
        reg_read(fsco_pkg::CFG_OPT_ADDR, got);
        chk_word({8'h00, got}, {8'h00, e});
        reg_read(16'h2F5C, got);
        chk_word({8'h00, got}, 16'h0000);
    endtask

    task automatic wait_mode(input logic par);
        int n;
        n = 0;
        while ((par ? par_mode : in_system_programming) !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        chk_bit(par ? par_mode : in_system_programming, 1'b1);
        chk_bit(par ? in_system_programming : par_mode, 1'b0);
    endtask

    // Debugger override pulse; outputs have settled when it returns
    task automatic dbg_write(input logic [7:0] d);
        @(posedge clk);
        dbg_we   <= 1'b1;
        dbg_data <= d;
        @(posedge clk);
        dbg_we <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Whole run is a few hundred cycles; this is far beyond it
    initial
    begin
        #1000000;
        err_count++;
        $display("unexpected %0t: watchdog expired", $time);
        end_sim();
    end

    initial
    begin
        logic [7:0] nv_list [4];
        nv_list = '{8'h00, 8'h75, 8'hAA, 8'hCE};
        err_count = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        nv_cfg = 8'h00;
        dbg_we = 1'b0;
        dbg_data = 8'h00;
        req = '0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        foreach (nv_list[k])
        begin
            do_reset(nv_list[k]);
            chk_opts(nv_list[k]);
        end
        do_reset(8'h00);
        chk_policy(8'h07);
        do_reset(8'h01);
        chk_policy(8'h07);
        do_req(2'd3, 1'b0, 16'h2000, 1'b0, 8'hFF, 1'b0);
        chk_bit(code_lock, 1'b1);
        u_fsco_tool.send_ser(12'hCC3);
        repeat (40) @(posedge clk);
        chk_bit(in_system_programming, 1'b0);
        do_reset(8'h02);
        u_fsco_tool.send_ser(12'hCCC);
        wait_mode(1'b0);
        chk_policy(8'hFF);
        do_req(2'd2, 1'b0, 16'h0100, 1'b0, 8'h00, 1'b0);
        do_req(2'd2, 1'b0, 16'h03FF, 1'b1, 8'h00, 1'b0);
        do_req(2'd2, 1'b0, 16'h0400, 1'b0, 8'h00, 1'b1);
        do_req(2'd1, 1'b0, 16'h0100, 1'b0, 8'h00, 1'b1);
        dbg_write(8'hFF);
        chk_opts(8'hF6);
        do_reset(8'h01);
        u_fsco_tool.send_par(12'h5A5);
        wait_mode(1'b1);
        dbg_write(8'hFF);
        chk_bit(sub_osc, 1'b0);
        chk_policy(8'h98);
        do_req(2'd3, 1'b0, 16'h2000, 1'b0, 8'h80, 1'b1);
        chk_bit(code_lock, 1'b1);
        do_req(2'd3, 1'b0, 16'h2000, 1'b0, 8'h81, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk_bit(code_lock, 1'b0);
        chk_policy(8'hFF);
        end_sim();
    end
endmodule
`default_nettype wire

/* tb/fsco_tool.sv */
// Behavioural programmer tool driving the debug pins and port nibble
`timescale 1ns/1ps
`default_nettype none
module fsco_tool (
    input  wire logic  clk_i,
    output logic       ser_data_o,
    output logic       ser_clk_o,
    output logic [3:0] par_nib_o
);
    localparam int HALF_NS = 200;

    initial
    begin
        ser_data_o = 1'b0;
        ser_clk_o  = 1'b0;
        par_nib_o  = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame MSB first, data set while clock low; clock idles low
    task automatic send_ser(input logic [11:0] bits);
        #37;
        for (int i = 11; i >= 0; i--)
        begin
            ser_data_o = bits[i];
            #(HALF_NS / 2);
            ser_clk_o = 1'b1;
            #HALF_NS;
            ser_clk_o = 1'b0;
            #(HALF_NS / 2);
        end
        // No pull on the line: show the inverse, never a stale level
        ser_data_o = ~bits[0];
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Three nibble steps, each held long enough to be sampled
    task automatic send_par(input logic [11:0] nibs);
        for (int i = 2; i >= 0; i--)
        begin
            @(posedge clk_i);
            par_nib_o <= nibs[i*4 +: 4];
            repeat (4) @(posedge clk_i);
        end
        @(posedge clk_i);
        par_nib_o <= ~nibs[3:0];
    endtask
endmodule
`default_nettype wire
